// *** bec_dev_access.sv ***
`timescale 1ns/10ps
module bec_dev_access
  import bec_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire bec_acc_t    req,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [3:0]       dev_addr,
  output logic [15:0]      dev_wdata,
  output logic             dev_wr,
  output logic             dev_rd,
  input  wire logic [15:0] dev_rdata
);

  logic [1:0] phase;

  // ----------------------------------------------------------------
  // One device access: write strobe one cycle, read data one later
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase     <= 2'h0;
      done      <= 1'b0;
      rdata     <= 16'h0000;
      dev_addr  <= 4'h0;
      dev_wdata <= 16'h0000;
      dev_wr    <= 1'b0;
      dev_rd    <= 1'b0;
    end else begin
      done   <= 1'b0;
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      unique case (phase)
        2'h0: begin
          if (start) begin
            dev_addr  <= req.addr;
            dev_wdata <= req.wr ? req.wdata : 16'h0000;
            dev_wr    <= req.wr;
            dev_rd    <= !req.wr;
            phase     <= req.wr ? 2'h2 : 2'h1;
          end
        end
        2'h1: begin
          phase <= 2'h3;
        end
        2'h3: begin
          rdata <= dev_rdata;
          done  <= 1'b1;
          phase <= 2'h0;
        end
        2'h2: begin
          done  <= 1'b1;
          phase <= 2'h0;
        end
      endcase
    end
  end

endmodule // bec_dev_access

// *** bec_dev_model.sv ***
`timescale 1ns/10ps
module bec_dev_model
  import bec_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [3:0]  dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic        dev_wr,
  input wire logic        dev_rd,
  input wire logic        in_tok,
  input wire logic        out_tok,
  output logic [15:0]     dev_rdata,
  output logic            dev_irq
);
  logic [15:0] r [16];
  logic [1:0]  tx_cnt;
  logic [1:0]  rx_cnt;
  logic        tx_tog;
  logic        rx_tog;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{default: 16'h0};
      tx_cnt <= 2'h2;
      {rx_cnt, tx_tog, rx_tog, dev_irq, dev_rdata} <= '0;
    end else begin
      dev_rdata <= !dev_rd ? ~dev_rdata : dev_addr != DEV_TX_CSR ?
        r[dev_addr] : {r[1][15:2], tx_cnt != 2'h0, r[1][0]};
      if (dev_rd && dev_addr inside {DEV_TX_CSR, DEV_RX_CSR}) dev_irq <= 1'b0;
      if (dev_wr) begin
        r[dev_addr] <= dev_wdata;
        if (dev_addr == DEV_TX_CSR) begin
          r[1][TX_STALLSENT] <= dev_wdata[TX_STALLSENT] & r[1][TX_STALLSENT];
          {r[1][TX_TOGRST], r[1][TX_DISCARD]} <= 2'h0;
          if (dev_wdata[TX_TOGRST]) tx_tog <= 1'b0;
          if (dev_wdata[TX_DISCARD] && tx_cnt != 2'h0) tx_cnt <= tx_cnt - 2'h1;
          if (dev_wdata[TX_LOADED]) tx_cnt <= tx_cnt + 2'h1;
          r[1][TX_LOADED] <= dev_wdata[TX_LOADED] & !r[3][FSZ_DBUF];
          if (dev_wdata[TX_LOADED] && r[3][FSZ_DBUF]) dev_irq <= 1'b1;
        end
        if (dev_addr == DEV_RX_CSR) begin
          r[2][RX_STALLSENT] <= dev_wdata[RX_STALLSENT] & r[2][RX_STALLSENT];
          {r[2][RX_TOGRST], r[2][RX_DISCARD]} <= 2'h0;
          if (dev_wdata[RX_TOGRST]) rx_tog <= 1'b0;
          if (dev_wdata[RX_DISCARD] && rx_cnt != 2'h0) rx_cnt <= rx_cnt - 2'h1;
        end
      end
      if (in_tok && r[1][TX_STALLREQ]) begin
        r[1][TX_STALLSENT] <= 1'b1;
        dev_irq <= 1'b1;
      end else if (in_tok && tx_cnt != 2'h0) begin
        tx_cnt <= tx_cnt - 2'h1;
        tx_tog <= ~tx_tog;
        r[1][TX_LOADED] <= 1'b0;
        if (!(r[1][TX_DMA_REQUEST_ENABLE] && r[1][TX_IRQSUP])) dev_irq <= 1'b1;
      end
      if (out_tok && r[2][RX_STALLREQ]) begin
        r[2][RX_STALLSENT] <= 1'b1;
        dev_irq <= 1'b1;
      end else if (out_tok && rx_cnt < (r[4][FSZ_DBUF] ? 2'h2 : 2'h1)) begin
        rx_cnt <= rx_cnt + 2'h1;
        rx_tog <= ~rx_tog;
        r[2][RX_AVAIL] <= 1'b1;
        if (!r[2][RX_DMA_REQUEST_ENABLE]) dev_irq <= 1'b1;
      end
    end
  end
endmodule // bec_dev_model

// *** bec_host_ctrl.sv ***
`timescale 1ns/10ps
module bec_host_ctrl
  import bec_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [31:0]      sw_rdata,
  output logic [3:0]       dev_addr,
  output logic [15:0]      dev_wdata,
  output logic             dev_wr,
  output logic             dev_rd,
  input  wire logic [15:0] dev_rdata,
  input  wire logic        dev_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic payload_ok(input logic [10:0] mp,
                                      input logic        hs);
    payload_ok = (mp == 11'h008) || (mp == 11'h010) ||
                 (mp == 11'h020) || (mp == 11'h040) ||
                 (hs && (mp == 11'h200));
  endfunction

  function automatic logic [15:0] tx_base(input logic [15:0] c,
                                          input logic        stall);
    logic [15:0] v;
    v = 16'h0000;
    v[TX_ISO]      = 1'b0;
    v[TX_SHARED]   = c[CFG_SHARED];
    v[TX_DMA_REQUEST_ENABLE]    = c[CFG_DMA];
    v[TX_FORCETOG] = 1'b0;
    v[TX_IRQSUP]   = c[CFG_DMA] & c[CFG_IRQSUP];
    v[TX_STALLREQ] = stall;
    tx_base = v;
  endfunction

  function automatic logic [15:0] rx_base(input logic [15:0] c,
                                          input logic        stall);
    logic [15:0] v;
    v = 16'h0000;
    v[RX_ISO]      = 1'b0;
    v[RX_DMA_REQUEST_ENABLE]    = c[CFG_DMA];
    v[RX_NYETDIS]  = 1'b0;
    v[RX_DMA_IRQ_SUPPRESS]  = 1'b0;
    v[RX_STALLREQ] = stall;
    rx_base = v;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bec_state_t  state;
  bec_state_t  next_state;
  logic [15:0] cfg;
  logic [10:0] pkt_len;
  logic [15:0] tx_img;
  logic [15:0] rx_img;
  logic        dir_rx;
  logic        tx_stall;
  logic        rx_stall;
  logic [1:0]  flushes;
  logic        pend;
  logic        acc_start;
  bec_acc_t    acc_req;
  logic        acc_done;
  logic [15:0] acc_rdata;
  logic        irq_lvl;
  logic        irq_prev;
  logic        evt_pend;
  logic        ev_txstall;
  logic        ev_rxstall;
  logic        ev_rxpkt;
  logic        err_busy;
  logic        err_param;
  logic [7:0]  cmd;
  logic        cmd_wr;
  logic        idle;
  logic        cmd_ok;
  logic        stat_clr;

  assign idle     = (state == S_IDLE) && !evt_pend;
  assign cmd_wr   = sw_wr && (sw_addr == SW_CMD_OFS);
  assign cmd      = sw_wdata[7:0];
  assign stat_clr = sw_wr && (sw_addr == SW_STAT_OFS);
  assign cmd_ok   = cmd_wr && idle &&
                    payload_ok(cfg[CFG_MAXP_W-1:0], cfg[CFG_HS]) &&
                    (pkt_len <= cfg[CFG_MAXP_W-1:0]);

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  bec_sync3 u_irq_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pin     (dev_irq),
    .level   (irq_lvl)
  );

  bec_dev_access u_acc (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .start     (acc_start),
    .req       (acc_req),
    .done      (acc_done),
    .rdata     (acc_rdata),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr    (dev_wr),
    .dev_rd    (dev_rd),
    .dev_rdata (dev_rdata)
  );

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg     <= CFG_RESET;
      pkt_len <= 11'h000;
    end else if (sw_wr && idle) begin
      if (sw_addr == SW_CFG_OFS) begin
        cfg <= sw_wdata[15:0];
      end
      if (sw_addr == SW_LEN_OFS) begin
        pkt_len <= sw_wdata[10:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    acc_start  = 1'b0;
    acc_req    = '{wr: 1'b0, addr: DEV_TX_CSR, wdata: 16'h0000};
    unique case (state)
      S_IDLE: begin
        if (evt_pend) begin
          next_state = S_EVTX;
        end else if (cmd_ok && (cmd[CMD_CFG_TX] || cmd[CMD_CFG_RX])) begin
          next_state = S_MAXP;
        end else if (cmd_ok && cmd[CMD_POLL]) begin
          next_state = S_EVTX;
        end else if (cmd_ok && |cmd[CMD_RXRESUME:CMD_SEND]) begin
          next_state = S_CSR;
        end
      end
      S_MAXP: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b1, addr: dir_rx ? DEV_RX_MAXP : DEV_TX_MAXP,
                      wdata: {5'h00, cfg[CFG_MAXP_W-1:0]}};
        if (acc_done) next_state = S_FSZ;
      end
      S_FSZ: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b1, addr: dir_rx ? DEV_RX_FSZ : DEV_TX_FSZ,
                      wdata: 16'(cfg[CFG_DBUF]) << FSZ_DBUF};
        if (acc_done) next_state = S_CSR;
      end
      S_CSR: begin
        acc_start = !pend;
        acc_req.wr = 1'b1;
        acc_req.addr = dir_rx ? DEV_RX_CSR : DEV_TX_CSR;
        acc_req.wdata = dir_rx ? rx_base(cfg, rx_stall)
                               : tx_base(cfg, tx_stall);
        if (flushes == 2'h3) begin
          acc_req.wdata[TX_LOADED] = 1'b1;
        end else if (flushes == 2'h2) begin
          acc_req.wdata[dir_rx ? RX_TOGRST : TX_TOGRST] = 1'b1;
        end
        if (acc_done) next_state = (flushes == 2'h2) ? S_RDBK : S_IDLE;
      end
      S_RDBK: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b0, addr: dir_rx ? DEV_RX_CSR : DEV_TX_CSR,
                      wdata: 16'h0000};
        if (acc_done) begin
          if ((dir_rx ? acc_rdata[RX_AVAIL] : acc_rdata[TX_OCCUPIED]) &&
              (flushes != 2'h0)) begin
            next_state = S_FLUSH;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_FLUSH: begin
        acc_start = !pend;
        acc_req.wr = 1'b1;
        acc_req.addr = dir_rx ? DEV_RX_CSR : DEV_TX_CSR;
        acc_req.wdata = dir_rx ? rx_base(cfg, rx_stall)
                               : tx_base(cfg, tx_stall);
        acc_req.wdata[dir_rx ? RX_DISCARD : TX_DISCARD] = 1'b1;
        if (acc_done) next_state = S_RDBK;
      end
      S_EVTX: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b0, addr: DEV_TX_CSR, wdata: 16'h0000};
        if (acc_done) begin
          next_state = acc_rdata[TX_STALLSENT] ? S_EVTXC : S_EVRX;
        end
      end
      S_EVTXC: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b1, addr: DEV_TX_CSR,
                      wdata: tx_base(cfg, tx_stall)};
        if (acc_done) next_state = S_EVRX;
      end
      S_EVRX: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b0, addr: DEV_RX_CSR, wdata: 16'h0000};
        if (acc_done) begin
          next_state = acc_rdata[RX_STALLSENT] ? S_EVRXC : S_IDLE;
        end
      end
      S_EVRXC: begin
        acc_start = !pend;
        acc_req   = '{wr: 1'b1, addr: DEV_RX_CSR,
                      wdata: rx_base(cfg, rx_stall)};
        if (acc_done) next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      pend  <= 1'b0;
    end else begin
      state <= next_state;
      if (acc_done) begin
        pend <= 1'b0;
      end else if (acc_start) begin
        pend <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operation context: direction, flush budget, stall requests
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir_rx   <= 1'b0;
      flushes  <= 2'h0;
      tx_stall <= 1'b0;
      rx_stall <= 1'b0;
    end else if (state == S_IDLE && !evt_pend && cmd_ok) begin
      dir_rx  <= cmd[CMD_CFG_RX] || cmd[CMD_RXSTALL] || cmd[CMD_RXRESUME];
      flushes <= 2'h0;
      if (cmd[CMD_CFG_TX] || cmd[CMD_CFG_RX]) begin
        flushes <= 2'h2;
      end else if (cmd[CMD_SEND]) begin
        flushes <= 2'h3;
      end else if (cmd[CMD_TXRESUME] || cmd[CMD_RXRESUME]) begin
        flushes <= 2'h2;
      end
      if (cmd[CMD_TXSTALL]) tx_stall <= 1'b1;
      if (cmd[CMD_TXRESUME]) tx_stall <= 1'b0;
      if (cmd[CMD_RXSTALL]) rx_stall <= 1'b1;
      if (cmd[CMD_RXRESUME]) rx_stall <= 1'b0;
    end else if (state == S_RDBK && acc_done) begin
      flushes <= (flushes == 2'h2 && cfg[CFG_DBUF]) ? 2'h1 : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Device interrupt capture and images
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_prev <= 1'b0;
      evt_pend <= 1'b0;
    end else begin
      irq_prev <= irq_lvl;
      if (irq_lvl && !irq_prev) begin
        evt_pend <= 1'b1;
      end else if (state == S_IDLE) begin
        evt_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_img <= 16'h0000;
      rx_img <= 16'h0000;
    end else if (acc_done && state == S_EVTX) begin
      tx_img <= acc_rdata;
    end else if (acc_done && state == S_EVRX) begin
      rx_img <= acc_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Sticky events and errors; a set in the clear cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ev_txstall <= 1'b0;
      ev_rxstall <= 1'b0;
      ev_rxpkt   <= 1'b0;
      err_busy   <= 1'b0;
      err_param  <= 1'b0;
    end else begin
      if (stat_clr && sw_wdata[ST_TXSTALL]) ev_txstall <= 1'b0;
      if (stat_clr && sw_wdata[ST_RXSTALL]) ev_rxstall <= 1'b0;
      if (stat_clr && sw_wdata[ST_RXPKT]) ev_rxpkt <= 1'b0;
      if (stat_clr && sw_wdata[ST_ERR_BUSY]) err_busy <= 1'b0;
      if (stat_clr && sw_wdata[ST_ERR_PARAM]) err_param <= 1'b0;
      if (acc_done && state == S_EVTX && acc_rdata[TX_STALLSENT]) begin
        ev_txstall <= 1'b1;
      end
      if (acc_done && state == S_EVRX && acc_rdata[RX_STALLSENT]) begin
        ev_rxstall <= 1'b1;
      end
      if (acc_done && state == S_EVRX && acc_rdata[RX_AVAIL]) begin
        ev_rxpkt <= 1'b1;
      end
      if (cmd_wr && !idle) begin
        err_busy <= 1'b1;
      end
      if (cmd_wr && idle && !cmd_ok) begin
        err_param <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sw_rdata <= 32'h0000_0000;
    end else if (sw_rd) begin
      unique case (sw_addr)
        SW_CFG_OFS:   sw_rdata <= {16'h0000, cfg};
        SW_LEN_OFS:   sw_rdata <= {21'h000000, pkt_len};
        SW_STAT_OFS:  sw_rdata <= {26'h0000000, err_param, err_busy,
                                   ev_rxpkt, ev_rxstall, ev_txstall,
                                   !idle};
        SW_TXIMG_OFS: sw_rdata <= {16'h0000, tx_img};
        SW_RXIMG_OFS: sw_rdata <= {16'h0000, rx_img};
        default:      sw_rdata <= 32'h0000_0000;
      endcase
    end else begin
      sw_rdata <= 32'h0000_0000;
    end
  end

endmodule // bec_host_ctrl

// *** bec_host_ctrl_chk.sv ***
`timescale 1ns/10ps
module bec_host_ctrl_chk
  import bec_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [3:0]  dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic        dev_wr,
  input wire logic        dev_rd
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic txw;
  logic rxw;
  assign txw = dev_wr && dev_addr == DEV_TX_CSR;
  assign rxw = dev_wr && dev_addr == DEV_RX_CSR;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_maxp; dev_wr && dev_addr == DEV_TX_MAXP |-> dev_wdata[10:0]
    inside {11'h008, 11'h010, 11'h020, 11'h040, 11'h200}; endproperty
  a_maxp: assert property (p_maxp) else $error("bad max payload");
  property p_txiso; txw |-> !dev_wdata[TX_ISO]; endproperty
  a_txiso: assert property (p_txiso) else $error("tx not bulk");
  property p_rxiso; rxw |-> !dev_wdata[RX_ISO]; endproperty
  a_rxiso: assert property (p_rxiso) else $error("rx not bulk");
  property p_rxmode; rxw |-> !dev_wdata[RX_DMA_IRQ_SUPPRESS]; endproperty
  a_rxmode: assert property (p_rxmode) else $error("rx mode set");
  property p_sup; txw && dev_wdata[TX_IRQSUP] |-> dev_wdata[TX_DMA_REQUEST_ENABLE];
  endproperty
  a_sup: assert property (p_sup) else $error("suppress without dma");
  property p_txs; txw |-> !dev_wdata[TX_STALLSENT]; endproperty
  a_txs: assert property (p_txs) else $error("stall flag written");
  property p_txcfg; dev_wr && dev_addr == DEV_TX_MAXP |->
    ##[1:16] (txw && dev_wdata[TX_TOGRST]); endproperty
  a_txcfg: assert property (p_txcfg) else $error("no toggle reset");
  property p_gap; (dev_wr || dev_rd) |=> !(dev_wr || dev_rd) [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("strobes too close");
  c_flush: cover property (txw && dev_wdata[TX_DISCARD]);
  c_send: cover property (txw && dev_wdata[TX_LOADED]);
  c_rxstall: cover property (rxw && dev_wdata[RX_STALLREQ]);
endmodule // bec_host_ctrl_chk
bind bec_host_ctrl bec_host_ctrl_chk bec_host_ctrl_chk_i (.ref_clk(ref_clk),
  .nrst(nrst), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
  .dev_rd(dev_rd));

// *** bec_pkg.sv ***
package bec_pkg;

  // ----------------------------------------------------------------
  // Software register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SW_CMD_OFS    = 8'h00;
  localparam logic [7:0] SW_CFG_OFS    = 8'h04;
  localparam logic [7:0] SW_LEN_OFS    = 8'h08;
  localparam logic [7:0] SW_STAT_OFS   = 8'h0c;
  localparam logic [7:0] SW_TXIMG_OFS  = 8'h10;
  localparam logic [7:0] SW_RXIMG_OFS  = 8'h14;

  // Command bits
  localparam int CMD_CFG_TX   = 0;
  localparam int CMD_CFG_RX   = 1;
  localparam int CMD_SEND     = 2;
  localparam int CMD_TXSTALL  = 3;
  localparam int CMD_TXRESUME = 4;
  localparam int CMD_RXSTALL  = 5;
  localparam int CMD_RXRESUME = 6;
  localparam int CMD_POLL     = 7;

  // Config register fields
  localparam int CFG_MAXP_W   = 11;
  localparam int CFG_DMA      = 11;
  localparam int CFG_IRQSUP   = 12;
  localparam int CFG_SHARED   = 13;
  localparam int CFG_DBUF     = 14;
  localparam int CFG_HS       = 15;
  localparam logic [15:0] CFG_RESET = 16'h0040;

  // Status register fields
  localparam int ST_BUSY      = 0;
  localparam int ST_TXSTALL   = 1;
  localparam int ST_RXSTALL   = 2;
  localparam int ST_RXPKT     = 3;
  localparam int ST_ERR_BUSY  = 4;
  localparam int ST_ERR_PARAM = 5;

  // ----------------------------------------------------------------
  // Device register map (word indices on the device port)
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TX_MAXP  = 4'h0;
  localparam logic [3:0] DEV_TX_CSR   = 4'h1;
  localparam logic [3:0] DEV_RX_CSR   = 4'h2;
  localparam logic [3:0] DEV_TX_FSZ   = 4'h3;
  localparam logic [3:0] DEV_RX_FSZ   = 4'h4;
  localparam logic [3:0] DEV_RX_MAXP  = 4'h5;

  // Transmit control/status bits
  localparam int TX_LOADED    = 0;
  localparam int TX_OCCUPIED  = 1;
  localparam int TX_DISCARD   = 3;
  localparam int TX_STALLREQ  = 4;
  localparam int TX_STALLSENT = 5;
  localparam int TX_TOGRST    = 6;
  localparam int TX_IRQSUP    = 10;
  localparam int TX_FORCETOG  = 11;
  localparam int TX_DMA_REQUEST_ENABLE     = 12;
  localparam int TX_SHARED    = 13;
  localparam int TX_ISO       = 14;

  // Receive control/status bits
  localparam int RX_AVAIL     = 0;
  localparam int RX_DISCARD   = 4;
  localparam int RX_STALLREQ  = 5;
  localparam int RX_STALLSENT = 6;
  localparam int RX_TOGRST    = 7;
  localparam int RX_DMA_IRQ_SUPPRESS   = 11;
  localparam int RX_NYETDIS   = 12;
  localparam int RX_DMA_REQUEST_ENABLE     = 13;
  localparam int RX_ISO       = 14;

  // FIFO sizing double-buffer bit
  localparam int FSZ_DBUF     = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_MAXP   = 4'b0001,
    S_FSZ    = 4'b0011,
    S_CSR    = 4'b0010,
    S_RDBK   = 4'b0110,
    S_FLUSH  = 4'b0111,
    S_EVTX   = 4'b0100,
    S_EVTXC  = 4'b1100,
    S_EVRX   = 4'b1101,
    S_EVRXC  = 4'b1111
  } bec_state_t;

  typedef struct packed {
    logic        wr;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } bec_acc_t;

endpackage

// *** bec_sync3.sv ***
`timescale 1ns/10ps
module bec_sync3
  import bec_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  // ----------------------------------------------------------------
  // Three stages; accept a change once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule // bec_sync3

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import bec_pkg::*;
  typedef struct packed {
    logic [1:0]  op;
    logic [7:0]  a;
    logic [15:0] d;
  } bec_row_t;
  logic        ref_clk, nrst, sw_wr, sw_rd, dev_wr, dev_rd, dev_irq;
  logic        in_tok, out_tok;
  logic [7:0]  sw_addr;
  logic [31:0] sw_wdata, sw_rdata, v;
  logic [3:0]  dev_addr;
  logic [15:0] dev_wdata, dev_rdata;
  int          failures, n_tests, cyc;
  // ----------------------------------------------------------------
  // Rows: op 0 write, 1 read and compare, 2 IN token, 3 OUT token
  // ----------------------------------------------------------------
  bec_row_t rows [40] = '{'{2'd1,8'h04,16'h40}, '{2'd0,8'h04,16'h4040},
    '{2'd0,8'h00,16'h1}, '{2'd1,8'h10,16'h0}, '{2'd0,8'h08,16'h0},
    '{2'd0,8'h00,16'h4}, '{2'd1,8'h10,16'h2}, '{2'd2,8'h00,16'h0},
    '{2'd1,8'h10,16'h0}, '{2'd0,8'h00,16'h8}, '{2'd2,8'h00,16'h0},
    '{2'd1,8'h0c,16'h2}, '{2'd1,8'h10,16'h30}, '{2'd0,8'h0c,16'h2},
    '{2'd2,8'h00,16'h0}, '{2'd1,8'h0c,16'h2}, '{2'd0,8'h00,16'h10},
    '{2'd0,8'h00,16'h2}, '{2'd3,8'h00,16'h0}, '{2'd1,8'h0c,16'ha},
    '{2'd1,8'h14,16'h1}, '{2'd0,8'h00,16'h20}, '{2'd3,8'h00,16'h0},
    '{2'd1,8'h0c,16'he}, '{2'd0,8'h0c,16'h3e}, '{2'd0,8'h04,16'h64},
    '{2'd0,8'h00,16'h1}, '{2'd1,8'h0c,16'h20}, '{2'd0,8'h0c,16'h20},
    '{2'd0,8'h04,16'h40},
    '{2'd0,8'h08,16'h41}, '{2'd0,8'h00,16'h4}, '{2'd1,8'h0c,16'h20},
    '{2'd0,8'h0c,16'h20}, '{2'd0,8'h04,16'h8200}, '{2'd0,8'h00,16'h1},
    '{2'd1,8'h0c,16'h0}, '{2'd0,8'h04,16'h200}, '{2'd0,8'h00,16'h1},
    '{2'd1,8'h0c,16'h20}};
  bec_host_ctrl bec_host_ctrl_i (.ref_clk(ref_clk), .nrst(nrst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_irq(dev_irq));
  bec_dev_model bec_dev_model_i (.ref_clk(ref_clk), .nrst(nrst),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .in_tok(in_tok), .out_tok(out_tok),
    .dev_rdata(dev_rdata), .dev_irq(dev_irq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    @(negedge ref_clk);
    d = sw_rdata;
  endtask
  task tok(input logic o);
    @(posedge ref_clk);
    {out_tok, in_tok} <= {o, !o};
    @(posedge ref_clk);
    {out_tok, in_tok} <= 2'h0;
  endtask
  task settle;
    logic [31:0] s;
    repeat (40) @(posedge ref_clk);
    for (int k = 0; k < 50; k++) begin
      rd(SW_STAT_OFS, s);
      if (s[ST_BUSY] === 1'b0) break;
    end
  endtask
  task test_done;
    $display("counts: %0d failures, %0d tests", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 30000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {nrst, sw_wr, sw_rd, in_tok, out_tok} = '0;
    {sw_addr, sw_wdata, failures, n_tests, cyc} = '0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].op == 2'd1) begin
        rd(rows[i].a, v);
        check(v, {16'h0, rows[i].d});
      end else begin
        if (rows[i].op == 2'd0) wr(rows[i].a, {16'h0, rows[i].d});
        else tok(rows[i].op[0]);
        settle();
      end
    end
    check({31'h0, bec_dev_model_i.tx_tog}, 32'h0);
    wr(SW_LEN_OFS, 32'h0);
    wr(SW_CFG_OFS, 32'h3840);
    wr(SW_CMD_OFS, 32'h1);
    settle();
    check({29'h0, bec_dev_model_i.r[1][TX_SHARED],
           bec_dev_model_i.r[1][TX_DMA_REQUEST_ENABLE],
           bec_dev_model_i.r[1][TX_IRQSUP]}, 32'h7);
    wr(SW_CMD_OFS, 32'h4);
    settle();
    tok(1'b0);
    repeat (2) @(posedge ref_clk);
    check({31'h0, dev_irq}, 32'h0);
    wr(SW_CMD_OFS, 32'h40);
    settle();
    check({31'h0, bec_dev_model_i.rx_tog}, 32'h0);
    wr(SW_STAT_OFS, 32'h3e);
    wr(SW_CMD_OFS, 32'h80);
    wr(SW_CMD_OFS, 32'h80);
    settle();
    rd(SW_STAT_OFS, v);
    check(v, 32'h10);
    rd(SW_TXIMG_OFS, v);
    check(v, 32'h3400);
    rd(8'hfc, v);
    check(v, 32'h0);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(SW_CFG_OFS, v);
    check(v, 32'h40);
    test_done();
  end
endmodule // tb_top
